// ==== sfbp_checker.sv ====
// Port assertions for the flash status and block-protect block.
// Bound to sfbp_top from the bench; core clock domain only.
`timescale 1ns/10ps
`default_nettype none
module sfbp_checker
	import sfbp_pkg::*;
#(
	parameter int SECTORS  = 32,
	parameter int SECTOR_W = 7
) (
	input wire logic                core_clk_in,
	input wire logic                reset_in,
	input wire logic                check_req_in,
	input wire logic                check_bulk_in,
	input wire logic [SECTOR_W-1:0] check_sector_in,
	input wire logic                check_grant_out,
	input wire logic                check_deny_out,
	input wire logic [2:0]          nv_level_out,
	input wire logic                nv_write_out,
	input wire logic [3:0]          reg_addr_in,
	input wire logic                reg_write_in,
	input wire logic                reg_read_in,
	input wire logic [7:0]          reg_rdata_out
);
	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (reset_in);
	logic exp_deny_q;
	// Guarded top sectors per level, all three variants
	function automatic int guard(logic [2:0] l);
		if (l == 3'h0) return 0;
		if (SECTORS == 128) return (l == 3'h7) ? 128 : 1 << l;
		if (l == 3'h7 || (SECTORS == 32 && l == 3'h6)) return SECTORS;
		return 1 << (l - 3'h1);
	endfunction : guard
	always_ff @(posedge core_clk_in) begin
		exp_deny_q <= int'(check_sector_in) >= SECTORS - guard(nv_level_out);
	end
	sequence s_ask;
		check_req_in;
	endsequence
	sequence s_one;
		check_grant_out != check_deny_out;
	endsequence
	check_one_a: assert property (s_ask |=> s_one)
		else $error("check answer not unique");
	check_quiet_a: assert property (!check_req_in |=>
		!check_grant_out && !check_deny_out) else $error("spurious answer");
	sector_map_a: assert property (check_req_in && !check_bulk_in |=>
		check_deny_out == exp_deny_q) else $error("sector map wrong");
	bulk_guard_a: assert property (check_req_in && check_bulk_in |=>
		check_deny_out == ($past(nv_level_out) != 3'h0)) else $error("bulk");
	rdata_idle_a: assert property (!reg_read_in |=> reg_rdata_out == 8'h00)
		else $error("read data outside read");
	status_top_a: assert property (reg_read_in &&
		reg_addr_in == SFBP_REG_STATUS |=> reg_rdata_out[7:5] == 3'h0 &&
		reg_rdata_out[4:2] == $past(nv_level_out)) else $error("status");
	level_hold_a: assert property ($changed(nv_level_out) |->
		nv_write_out || $past(reg_write_in) || $past(reg_write_in, 2) ||
		$past(reset_in)) else $error("level changed alone");
	nv_pulse_a: assert property (nv_write_out |=> !nv_write_out)
		else $error("write pulse too long");
endmodule : sfbp_checker
`default_nettype wire

// ==== sfbp_host.sv ====
// Host model on the serial link: select, shift clock and command line.
// Shift clock stands still outside frames; 125 ns period.
`timescale 1ns/10ps
`default_nettype none
module sfbp_host (
	output logic     sclk_out,
	output logic     sel_low_out,
	output logic     mosi_out,
	input wire logic miso_in
);
	initial begin
		sclk_out = 1'b0;
		sel_low_out = 1'b1;
		mosi_out = 1'b0;
	end
	// Sends n bits of tx from the top; short n models an aborted frame
	task automatic frame(input logic [23:0] tx, input int n,
		output logic [23:0] rx);
		rx = 24'h0;
		sel_low_out = 1'b0;
		for (int i = 0; i < n; i++) begin
			mosi_out = tx[23 - i];
			#62.5 sclk_out = 1'b1;
			rx[23 - i] = miso_in;
			#62.5 sclk_out = 1'b0;
		end
		#62.5 sel_low_out = 1'b1;
		mosi_out = ~mosi_out;
		#100;
	endtask : frame
endmodule : sfbp_host
`default_nettype wire

// ==== sfbp_link.sv ====
// Serial link front end, clocked by the host's shift clock.
// Assumes the shift clock runs only while select is low; edges outside
// a frame are not expected.
`timescale 1ns/10ps
`default_nettype none
module sfbp_link
	import sfbp_pkg::*;
(
	input  wire logic       serial_shift_clock_in,
	input  wire logic       select_low_in,
	input  wire logic       reset_in,
	input  wire logic       serial_command_input_in,
	input  wire logic [7:0] status_in,
	output logic            ws_armed_out,
	output logic            wren_armed_out,
	output logic [7:0]      ws_data_out,
	output logic            serial_data_out,
	output logic            serial_data_oe_out
);

	typedef struct packed {
		logic [4:0] cnt;
		logic [2:0] pos;
		logic [7:0] op;
		logic [7:0] sh;
		logic [7:0] st_m;
		logic [7:0] st_s;
	} sfbp_frame_t;

	typedef struct packed {
		logic       ws_armed;
		logic       wren_armed;
		logic [7:0] data;
	} sfbp_hold_t;

	typedef struct packed {
		logic dout;
		logic doe;
	} sfbp_out_t;

	sfbp_frame_t frame_q, frame_d;
	sfbp_hold_t  hold_q,  hold_d;
	sfbp_out_t   out_q,   out_d;
	logic [7:0]  op_next;

	always_comb begin
		frame_d = frame_q;
		hold_d  = hold_q;
		op_next = {frame_q.op[6:0], serial_command_input_in};
		frame_d.cnt = (frame_q.cnt == SFBP_CNT_MAX) ? frame_q.cnt
			: frame_q.cnt + 5'h01;
		frame_d.pos = frame_q.pos + 3'h1; // [R6]
		frame_d.sh  = {frame_q.sh[6:0], serial_command_input_in};
		if (frame_q.cnt < SFBP_CNT_OP_DONE) begin
			frame_d.op = op_next; // [R7]
		end
		// Status is mostly static; a synchroniser suffices per bit
		frame_d.st_m = status_in;
		frame_d.st_s = frame_q.st_m;
		case (frame_q.cnt)
			5'h00: begin
				hold_d.ws_armed   = 1'b0;
				hold_d.wren_armed = 1'b0;
			end
			SFBP_CNT_OP_LAST: begin
				hold_d.wren_armed = (op_next == SFBP_OP_WRITE_ENABLE);
			end
			SFBP_CNT_OP_DONE: begin
				hold_d.wren_armed = 1'b0;
			end
			SFBP_CNT_WS_LAST: begin
				hold_d.ws_armed = (frame_q.op == SFBP_OP_WRITE_STATUS); // [R11]
				hold_d.data     = {frame_q.sh[6:0], serial_command_input_in};
			end
			SFBP_CNT_WS_OVER: begin
				hold_d.ws_armed = 1'b0; // [R12]
			end
			default: begin
				hold_d.ws_armed = hold_q.ws_armed;
			end
		endcase
		out_d.doe  = (frame_q.cnt >= SFBP_CNT_OP_DONE) &&
			(frame_q.op == SFBP_OP_READ_STATUS); // [R4] [R16]
		out_d.dout = out_d.doe ? frame_q.st_s[~frame_q.pos] : 1'b0; // [R6]
	end

	// Frame counters end with the frame itself, not with a clock edge
	always_ff @(posedge serial_shift_clock_in or posedge select_low_in) begin
		if (select_low_in) begin
			frame_q <= '0;
		end else begin
			frame_q <= frame_d;
		end
	end

	// Verdicts must outlive the frame so the core can read them
	always_ff @(posedge serial_shift_clock_in or posedge reset_in) begin
		if (reset_in) begin
			hold_q <= '0;
		end else begin
			hold_q <= hold_d;
		end
	end

	always_ff @(negedge serial_shift_clock_in or posedge select_low_in) begin
		if (select_low_in) begin
			out_q <= '0;
		end else begin
			out_q <= out_d;
		end
	end

	assign ws_armed_out       = hold_q.ws_armed;
	assign wren_armed_out     = hold_q.wren_armed;
	assign ws_data_out        = hold_q.data;
	assign serial_data_out    = out_q.dout;
	assign serial_data_oe_out = out_q.doe;

endmodule : sfbp_link
`default_nettype wire

// ==== sfbp_pkg.sv ====
// Constants and types for the flash status and block-protect block.
// Assumes a 100 MHz core clock and a host-driven serial link clock.
package sfbp_pkg;

	localparam logic [7:0] SFBP_OP_WRITE_STATUS = 8'h01;
	localparam logic [7:0] SFBP_OP_READ_STATUS  = 8'h05;
	localparam logic [7:0] SFBP_OP_WRITE_ENABLE = 8'h06;

	localparam int SFBP_WIP_BIT = 0;
	localparam int SFBP_WEL_BIT = 1;
	localparam int SFBP_BP_LSB  = 2;
	localparam int SFBP_BP_W    = 3;

	localparam logic [4:0] SFBP_CNT_OP_LAST  = 5'h07;
	localparam logic [4:0] SFBP_CNT_OP_DONE  = 5'h08;
	localparam logic [4:0] SFBP_CNT_WS_LAST  = 5'h0F;
	localparam logic [4:0] SFBP_CNT_WS_OVER  = 5'h10;
	localparam logic [4:0] SFBP_CNT_MAX      = 5'h11;

	localparam logic [2:0] SFBP_BP_RESET = 3'h0;

	localparam int SFBP_CORE_PERIOD_PS = 10000;
	localparam int SFBP_WS_TYP_MS      = 5;
	localparam int SFBP_WS_MAX_MS      = 15;
	localparam int SFBP_WS_CYCLES =
		SFBP_WS_TYP_MS * (1000000000 / SFBP_CORE_PERIOD_PS);
	localparam int SFBP_WS_MAX_CYCLES =
		SFBP_WS_MAX_MS * (1000000000 / SFBP_CORE_PERIOD_PS);

	localparam logic [3:0] SFBP_REG_STATUS  = 4'h0;
	localparam logic [3:0] SFBP_REG_CHECK   = 4'h1;
	localparam logic [3:0] SFBP_REG_PROTECT = 4'h2;
	localparam logic [3:0] SFBP_REG_WRITES  = 4'h3;
	localparam logic [3:0] SFBP_REG_CTRL    = 4'h4;
	localparam int         SFBP_CTRL_RELOAD = 0;

	typedef enum logic [1:0] {
		SFBP_IDLE = 2'b01,
		SFBP_BUSY = 2'b10
	} sfbp_state_t;

endpackage : sfbp_pkg

// ==== sfbp_top.sv ====
// Status register, self-timed status write and sector protection.
// Assumes the host supplies the shift clock and keeps select high for
// several core cycles between frames.
//
// How it works
// [R1] 32 sectors: levels 1-5 guard top 1,2,4,8,16 sectors; 6,7 guard all.
// [R2] 128 sectors: levels 1-6 guard top 2..64 sectors; 7 guards all.
// [R3] 64 sectors: levels 1-6 guard top 1..32 sectors; 7 guards all.
// [R4] Status can be read in any frame, even during a busy cycle.
// [R5] Busy flag sits in status bit 0.
// [R6] Status byte repeats on the output while select stays low.
// [R7] Write-status opcode is 0x01, shifted most significant bit first.
// [R8] Write-status changes only the three protect-level bits.
// [R9] Sectors covered by the protect level refuse program and erase.
// [R10] Host sets the write-enable latch before each write-status.
// [R11] Host sends opcode then exactly one data byte under select.
// [R12] Select rising after other than sixteen bits cancels write-status.
// [R13] Self-timed write starts on select rising; lasts 5 ms, under 15 ms.
// [R14] Busy reads one for the whole timed write, zero afterwards.
// [R15] Host waits out the write time or polls busy.
// [R16] Read-status opcode is 0x05, shifted most significant bit first.
// [R17] Write-enable latch is status bit 1, cleared when a write completes.
// [R18] Bulk erase is allowed only when the protect level is zero.
// [R19] Protect level is kept in non-volatile storage across power loss.
//
// Decided for this implementation: the register addresses and the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
module sfbp_top
	import sfbp_pkg::*;
#(
	parameter int SECTORS    = 32,
	parameter int SECTOR_W   = 7,
	parameter int WS_CYCLES  = SFBP_WS_CYCLES,
	parameter int TIMER_W    = 20
) (
	input  wire logic                core_clk_in,
	input  wire logic                reset_in,
	input  wire logic                serial_shift_clock_in,
	input  wire logic                select_low_in,
	input  wire logic                serial_command_input_in,
	output logic                     serial_data_out,
	output logic                     serial_data_oe_out,
	input  wire logic                check_req_in,
	input  wire logic                check_bulk_in,
	input  wire logic [SECTOR_W-1:0] check_sector_in,
	output logic                     check_grant_out,
	output logic                     check_deny_out,
	input  wire logic [2:0]          nv_level_in,
	output logic [2:0]               nv_level_out,
	output logic                     nv_write_out,
	input  wire logic [3:0]          reg_addr_in,
	input  wire logic [7:0]          reg_wdata_in,
	input  wire logic                reg_write_in,
	input  wire logic                reg_read_in,
	output logic [7:0]               reg_rdata_out
);

	typedef struct packed {
		logic               sel_m;
		logic               sel_s;
		logic               sel_p;
		logic               ws_m;
		logic               ws_s;
		logic               wren_m;
		logic               wren_s;
		sfbp_state_t        state;
		logic [TIMER_W-1:0] timer;
		logic [2:0]         bp;
		logic [2:0]         pend;
		logic               wel;
		logic               wip;
		logic               grant;
		logic               deny;
		logic               nv_write;
		logic [7:0]         writes;
		logic [7:0]         rdata;
	} sfbp_core_t;

	sfbp_core_t core_q, core_d;

	logic       ws_armed;
	logic       wren_armed;
	logic [7:0] ws_data;
	logic [7:0] status_byte;
	logic       sel_rise;
	logic       hit;

	// Number of top sectors guarded by a protect level
	function automatic int guard_count(input logic [2:0] level);
		int n;
		n = 0;
		if (level != 3'h0) begin
			if (SECTORS == 32) begin
				n = (level >= 3'h6) ? 32 : (1 << (level - 3'h1)); // [R1]
			end else if (SECTORS == 64) begin
				n = (level == 3'h7) ? 64 : (1 << (level - 3'h1)); // [R3]
			end else begin
				n = (level == 3'h7) ? SECTORS : (1 << level); // [R2]
			end
		end
		return n;
	endfunction : guard_count

	function automatic logic sector_guarded(input logic [2:0] level,
		input logic [SECTOR_W-1:0] sector);
		int n;
		n = guard_count(level);
		return (n != 0) && (int'(sector) >= SECTORS - n);
	endfunction : sector_guarded

	sfbp_link u_link (
		.serial_shift_clock_in   (serial_shift_clock_in),
		.select_low_in           (select_low_in),
		.reset_in                (reset_in),
		.serial_command_input_in (serial_command_input_in),
		.status_in               (status_byte),
		.ws_armed_out            (ws_armed),
		.wren_armed_out          (wren_armed),
		.ws_data_out             (ws_data),
		.serial_data_out         (serial_data_out),
		.serial_data_oe_out      (serial_data_oe_out)
	);

	always_comb begin
		status_byte = 8'h00;
		status_byte[SFBP_WIP_BIT] = core_q.wip; // [R5] [R14]
		status_byte[SFBP_WEL_BIT] = core_q.wel; // [R17]
		status_byte[SFBP_BP_LSB +: SFBP_BP_W] = core_q.bp;
	end

	// Only the second stage of each synchroniser feeds logic
	assign sel_rise = core_q.sel_s & ~core_q.sel_p;

	always_comb begin
		if (check_bulk_in) begin
			hit = (core_q.bp != 3'h0); // [R18]
		end else begin
			hit = sector_guarded(core_q.bp, check_sector_in); // [R9]
		end
	end

	always_comb begin
		core_d          = core_q;
		core_d.sel_m    = select_low_in;
		core_d.sel_s    = core_q.sel_m;
		core_d.sel_p    = core_q.sel_s;
		core_d.ws_m     = ws_armed;
		core_d.ws_s     = core_q.ws_m;
		core_d.wren_m   = wren_armed;
		core_d.wren_s   = core_q.wren_m;
		core_d.nv_write = 1'b0;
		core_d.grant    = check_req_in & ~hit;
		core_d.deny     = check_req_in & hit;
		case (core_q.state)
			SFBP_IDLE: begin
				core_d.wip = 1'b0;
				// Commands arriving mid-cycle are dropped, as the cycle owns
				// the protect bits until it ends
				if (sel_rise) begin
					if (core_q.ws_s && core_q.wel) begin // [R10] [R12]
						core_d.state = SFBP_BUSY; // [R13]
						core_d.wip   = 1'b1; // [R14]
						core_d.timer = TIMER_W'(WS_CYCLES - 1);
						// Data byte is frozen: the link clock is stopped
						core_d.pend  = ws_data[SFBP_BP_LSB +: SFBP_BP_W]; // [R8]
					end else if (core_q.wren_s) begin
						core_d.wel = 1'b1;
					end
				end
				if (reg_write_in && (reg_addr_in == SFBP_REG_CTRL) &&
					reg_wdata_in[SFBP_CTRL_RELOAD]) begin
					core_d.bp = nv_level_in; // [R19]
				end
			end
			SFBP_BUSY: begin
				core_d.wip = 1'b1; // [R14]
				if (core_q.timer == '0) begin
					core_d.state    = SFBP_IDLE;
					core_d.wip      = 1'b0; // [R14]
					core_d.bp       = core_q.pend; // [R8]
					core_d.wel      = 1'b0; // [R17]
					core_d.nv_write = 1'b1; // [R19]
					core_d.writes   = core_q.writes + 8'h01;
				end else begin
					core_d.timer = core_q.timer - TIMER_W'(1); // [R13]
				end
			end
			default: begin
				core_d.state = SFBP_IDLE;
				core_d.wip   = 1'b0;
			end
		endcase
		core_d.rdata = 8'h00;
		if (reg_read_in) begin
			case (reg_addr_in)
				SFBP_REG_STATUS:  core_d.rdata = status_byte; // [R4]
				SFBP_REG_CHECK:   core_d.rdata = {6'h00, core_q.deny,
					core_q.grant};
				SFBP_REG_PROTECT: core_d.rdata = 8'(guard_count(core_q.bp));
				SFBP_REG_WRITES:  core_d.rdata = core_q.writes;
				default:          core_d.rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (reset_in) begin
			core_q          <= '0;
			core_q.sel_m    <= 1'b1;
			core_q.sel_s    <= 1'b1;
			core_q.sel_p    <= 1'b1;
			core_q.state    <= SFBP_IDLE;
			// Protect level reloads from storage, not from a fixed value
			core_q.bp       <= nv_level_in; // [R19]
			core_q.pend     <= SFBP_BP_RESET;
		end else begin
			core_q <= core_d;
		end
	end

	assign check_grant_out = core_q.grant;
	assign check_deny_out  = core_q.deny;
	assign nv_level_out    = core_q.bp;
	assign nv_write_out    = core_q.nv_write;
	assign reg_rdata_out   = core_q.rdata;

endmodule : sfbp_top
`default_nettype wire

// ==== tb.sv ====
// Self-checking bench for the flash status and block-protect block.
// Link traffic comes from the host model, registers from the bench.
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin \
	failures++; $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module tb;
	import sfbp_pkg::*;
	localparam int WS = 600;
	logic core_clk_in, reset_in, serial_shift_clock_in, select_low_in;
	logic serial_command_input_in, serial_data_out, serial_data_oe_out;
	logic check_req_in, check_bulk_in, check_grant_out, check_deny_out;
	logic [6:0] check_sector_in;
	logic [2:0] nv_level_in, nv_level_out;
	logic nv_write_out, reg_write_in, reg_read_in, miso;
	logic [3:0] reg_addr_in;
	logic [7:0] reg_wdata_in, reg_rdata_out, rv;
	logic [23:0] rx;
	logic [6:0] sec64, sec128;
	logic gr64, dn64, gr128, dn128;
	int failures = 0;
	int checks_done = 0;
	int gtab[8] = '{0, 1, 2, 4, 8, 16, 32, 32};
	int g64[8] = '{0, 1, 2, 4, 8, 16, 32, 64};
	int g128[8] = '{0, 2, 4, 8, 16, 32, 64, 128};
	assign miso = serial_data_oe_out & serial_data_out;
	sfbp_top #(.SECTORS(32), .WS_CYCLES(WS)) DUT (.core_clk_in, .reset_in,
		.serial_shift_clock_in, .select_low_in, .serial_command_input_in,
		.serial_data_out, .serial_data_oe_out, .check_req_in,
		.check_bulk_in, .check_sector_in, .check_grant_out, .check_deny_out,
		.nv_level_in, .nv_level_out, .nv_write_out, .reg_addr_in,
		.reg_wdata_in, .reg_write_in, .reg_read_in, .reg_rdata_out);
	// Other two density builds share every input but the sector number
	sfbp_top #(.SECTORS(64), .WS_CYCLES(WS)) DUT_64 (.core_clk_in,
		.reset_in, .serial_shift_clock_in, .select_low_in,
		.serial_command_input_in, .serial_data_out(),
		.serial_data_oe_out(), .check_req_in, .check_bulk_in,
		.check_sector_in(sec64), .check_grant_out(gr64),
		.check_deny_out(dn64), .nv_level_in, .nv_level_out(),
		.nv_write_out(), .reg_addr_in, .reg_wdata_in, .reg_write_in,
		.reg_read_in, .reg_rdata_out());
	sfbp_top #(.SECTORS(128), .WS_CYCLES(WS)) DUT_128 (.core_clk_in,
		.reset_in, .serial_shift_clock_in, .select_low_in,
		.serial_command_input_in, .serial_data_out(),
		.serial_data_oe_out(), .check_req_in, .check_bulk_in,
		.check_sector_in(sec128), .check_grant_out(gr128),
		.check_deny_out(dn128), .nv_level_in, .nv_level_out(),
		.nv_write_out(), .reg_addr_in, .reg_wdata_in, .reg_write_in,
		.reg_read_in, .reg_rdata_out());
	sfbp_host host (.sclk_out(serial_shift_clock_in),
		.sel_low_out(select_low_in), .mosi_out(serial_command_input_in),
		.miso_in(miso));
	initial begin
		core_clk_in = 1'b0;
		forever #5 core_clk_in = ~core_clk_in;
	end
	task automatic summarize();
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : summarize
	task automatic reg_rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge core_clk_in);
		reg_addr_in <= a;
		reg_read_in <= 1'b1;
		@(posedge core_clk_in);
		reg_read_in <= 1'b0;
		#1 d = reg_rdata_out;
	endtask : reg_rd
	// Lowest guarded sector, or the top one when nothing is guarded
	function automatic int lo_s(input int t, input int g);
		return (g == 0) ? t - 1 : t - g;
	endfunction : lo_s
	// Highest free sector, or sector 0 when all are guarded
	function automatic int hi_s(input int t, input int g);
		return (g == t) ? 0 : t - g - 1;
	endfunction : hi_s
	// Sectors and expected refusals for the 32, 64 and 128 sector builds
	task automatic ask(input logic b, input int s0, input int s1,
		input int s2, input logic d0, input logic d1, input logic d2);
		@(posedge core_clk_in);
		check_req_in <= 1'b1;
		check_bulk_in <= b;
		check_sector_in <= s0[6:0];
		sec64 <= s1[6:0];
		sec128 <= s2[6:0];
		@(posedge core_clk_in);
		check_req_in <= 1'b0;
		reg_addr_in <= SFBP_REG_CHECK;
		reg_read_in <= 1'b1;
		#1 `CHK("deny", d0, check_deny_out)
		`CHK("grant", ~d0, check_grant_out)
		`CHK("deny 64", d1, dn64)
		`CHK("grant 64", ~d1, gr64)
		`CHK("deny 128", d2, dn128)
		`CHK("grant 128", ~d2, gr128)
		@(posedge core_clk_in);
		reg_read_in <= 1'b0;
		#1 `CHK("last check", {d0, ~d0}, reg_rdata_out)
	endtask : ask
	task automatic ws_frame(input logic [7:0] d, input int n);
		host.frame({SFBP_OP_WRITE_STATUS, d, 8'h00}, n, rx);
	endtask : ws_frame
	task automatic t_abort();
		reg_rd(SFBP_REG_STATUS, rv);
		`CHK("reset status", 8'h00, rv)
		reg_rd(4'hF, rv);
		`CHK("unmapped", 8'h00, rv)
		host.frame({SFBP_OP_WRITE_ENABLE, 16'h0}, 8, rx);
		ws_frame(8'hFF, 15);
		ws_frame(8'hFF, 17);
		repeat (20) @(posedge core_clk_in);
		reg_rd(SFBP_REG_STATUS, rv);
		`CHK("abort status", 8'h02, rv)
		$display("test abort done");
	endtask : t_abort
	task automatic t_write();
		realtime t0;
		int n;
		host.frame({SFBP_OP_WRITE_ENABLE, 16'h0}, 8, rx);
		ws_frame(8'hF7, 16);
		t0 = $realtime;
		host.frame({SFBP_OP_READ_STATUS, 16'h0}, 24, rx);
		`CHK("busy byte", 8'h03, rx[15:8])
		`CHK("busy byte again", 8'h03, rx[7:0])
		reg_rd(SFBP_REG_STATUS, rv);
		`CHK("busy reg", 1'b1, rv[SFBP_WIP_BIT])
		n = 0;
		do begin
			@(posedge core_clk_in);
			#1 n++;
		end while (nv_write_out !== 1'b1 && n < 1000);
		if (n >= 1000) begin
			failures++;
			summarize();
		end
		n = int'(($realtime - t0) / 10.0) + 10;
		`CHK("write time", 1'b1, n >= WS && n <= WS + 8)
		`CHK("level", 3'h5, nv_level_out)
		reg_rd(SFBP_REG_STATUS, rv);
		`CHK("status done", 8'h14, rv)
		reg_rd(SFBP_REG_WRITES, rv);
		`CHK("write count", 8'h01, rv)
		// Write without the latch set must be refused
		ws_frame(8'h00, 16);
		repeat (20) @(posedge core_clk_in);
		reg_rd(SFBP_REG_STATUS, rv);
		`CHK("no latch", 8'h14, rv)
		$display("test write done");
	endtask : t_write
	task automatic t_check();
		for (int l = 0; l < 8; l++) begin
			@(posedge core_clk_in);
			nv_level_in <= l[2:0];
			reg_addr_in <= SFBP_REG_CTRL;
			reg_wdata_in <= 8'h01;
			reg_write_in <= 1'b1;
			@(posedge core_clk_in);
			reg_write_in <= 1'b0;
			repeat (2) @(posedge core_clk_in);
			`CHK("reload", l[2:0], nv_level_out)
			ask(1'b0, lo_s(32, gtab[l]), lo_s(64, g64[l]),
				lo_s(128, g128[l]), gtab[l] != 0, g64[l] != 0,
				g128[l] != 0);
			ask(1'b0, hi_s(32, gtab[l]), hi_s(64, g64[l]),
				hi_s(128, g128[l]), gtab[l] == 32, g64[l] == 64,
				g128[l] == 128);
			ask(1'b1, 0, 0, 0, l != 0, l != 0, l != 0);
			reg_rd(SFBP_REG_PROTECT, rv);
			`CHK("guarded count", 8'(gtab[l]), rv)
		end
		$display("test check done");
	endtask : t_check
	// Mid-run reset must reload the level from storage
	task automatic t_reset();
		@(posedge core_clk_in);
		nv_level_in <= 3'h3;
		reset_in <= 1'b1;
		repeat (2) @(posedge core_clk_in);
		reset_in <= 1'b0;
		@(posedge core_clk_in);
		#1 `CHK("reset level", 3'h3, nv_level_out)
		reg_rd(SFBP_REG_STATUS, rv);
		`CHK("reload status", 8'h0C, rv)
		$display("test reset done");
	endtask : t_reset
	initial begin
		reset_in = 1'b1;
		check_req_in = 1'b0;
		check_bulk_in = 1'b0;
		check_sector_in = 7'h00;
		sec64 = 7'h00;
		sec128 = 7'h00;
		nv_level_in = 3'h0;
		reg_addr_in = 4'h0;
		reg_wdata_in = 8'h00;
		reg_write_in = 1'b0;
		reg_read_in = 1'b0;
		repeat (2) @(posedge core_clk_in);
		reset_in <= 1'b0;
		t_abort();
		t_write();
		t_check();
		t_reset();
		summarize();
	end
endmodule : tb
bind sfbp_top sfbp_checker #(.SECTORS(SECTORS), .SECTOR_W(SECTOR_W)) chk (
	.core_clk_in, .reset_in, .check_req_in, .check_bulk_in,
	.check_sector_in, .check_grant_out, .check_deny_out, .nv_level_out,
	.nv_write_out, .reg_addr_in, .reg_write_in, .reg_read_in,
	.reg_rdata_out);
`default_nettype wire
